// ---- ecpc_regs.svh ----
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, 100 MHz sys_clk
// Notes: offsets are register indices on the byte register port
`ifndef ECPC_REGS_SVH
`define ECPC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ECPC_OFF_STORED_CRC 8'h2F
`define ECPC_OFF_PROG_COUNT 8'h30
`define ECPC_OFF_NV_CONTROL 8'h31
`define ECPC_OFF_LIVE_CRC 8'h32
`define ECPC_OFF_ARRAY_PTR 8'h33
`define ECPC_OFF_NV_READ 8'h34
`define ECPC_OFF_SHADOW_RAM 8'h35
`define ECPC_OFF_UNLOCK_KEY 8'h38
// ****************************************
// Control field positions
// ****************************************
`define ECPC_BIT_REG_COPY 6
`define ECPC_BIT_CRC_ERR 5
`define ECPC_BIT_AUTO_CRC 4
`define ECPC_BIT_NV_LOAD 3
`define ECPC_BIT_BUSY 2
`define ECPC_BIT_ERASE 1
`define ECPC_BIT_PROGRAM 0
// ****************************************
// Values
// ****************************************
`define ECPC_UNLOCK_VALUE 8'hBE
`define ECPC_RST_AUTO_CRC 1'b1
`define ECPC_RST_ZERO 8'h00
`define ECPC_COUNT_MAX 8'hFF
`define ECPC_ARRAY_WORDS 32
`define ECPC_LIVE_REGS 16
`define ECPC_CRC_ADDR 5'h1F
`define ECPC_COUNT_ADDR 5'h1E
`define ECPC_CRC_POLY 8'h07
// ****************************************
// Timing
// ****************************************
`define ECPC_CLK_MHZ 100
`define ECPC_CYCLE_MS 115
`define ECPC_CYCLE_CLKS (`ECPC_CYCLE_MS * 1000 * `ECPC_CLK_MHZ)
`endif

// ---- ecpc_pkg.sv ----
// Purpose: types shared by the nonvolatile control block
// Assumes: constants come from ecpc_regs.svh
// Notes: states are one-hot
package ecpc_pkg;
    typedef enum logic [5:0] {
        ECPC_IDLE = 6'h01,
        ECPC_LOAD = 6'h02,
        ECPC_COPY = 6'h04,
        ECPC_ERASE = 6'h08,
        ECPC_PROG = 6'h10,
        ECPC_SUM = 6'h20
    } ecpc_state_e;
    typedef logic [7:0] ecpc_byte_t;
    typedef logic [4:0] ecpc_addr_t;
endpackage

// ---- ecpc_mem.sv ----
// Purpose: small byte memory with registered read data
// Assumes: one write port and one read port on sys_clk
// Notes: contents start cleared at power-up and are not touched by reset
module ecpc_mem #(
    parameter int WORDS = 32,
    parameter int AW = 5
) (
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // Cleared start keeps the first checksum and count defined
    logic [7:0] mem_q [WORDS] = '{default: 8'h00};

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule // ecpc_mem

// ---- ecpc_top.sv ----
// Purpose: nonvolatile array control: load, copy, erase, program, checksum
// Assumes: byte register port on sys_clk; live registers outside as a flat bus
// Notes: the array is modelled as two memories, shadow and nonvolatile
// Notes on behaviour
// - Writing copy bit moves live registers into shadow array, then bit self-clears
// - Checksum mismatch found while loading at configuration sets the mismatch flag
// - With auto checksum enabled, each program computes and stores the checksum
// - Load array into live registers after reset and on load request; self-clears
// - Register reads are not served while a load is running
// - Busy flag is high over erase or program; array access other than shadow reads refused meanwhile
// - Erase starts only when previous transaction wrote the unlock key; about 115 ms
// - Program starts only when previous transaction wrote the unlock key; about 115 ms
// - Erase and program together run one erase then program cycle
// - Live checksum byte is read-only and resets to zero
// - Seven bit pointer gives start; internal copy increments, pointer unchanged
// - Array byte address uses only the low five pointer bits
// - Nonvolatile read port returns stored bytes from pointer onward
// - Shadow port reads and writes shadow memory at tracked address
// - Stored checksum byte from the array is kept read-only
// - Cycle counter increments after each erase or program, once for erase and program together, saturating at 255
`include "ecpc_regs.svh"
module ecpc_top import ecpc_pkg::*; #(
    parameter int CYCLE_CLKS = `ECPC_CYCLE_CLKS,
    parameter int LIVE_REGS = `ECPC_LIVE_REGS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port, one transaction per strobe
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Live configuration registers
    input wire logic [LIVE_REGS*8-1:0] live_regs,
    output logic [7:0] load_data,
    output logic [4:0] load_addr,
    output logic load_we,
    // Status
    output logic nv_busy,
    output logic load_active
);
    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        ecpc_state_e st;
        logic [31:0] timer;
        logic [5:0] idx;
        logic erase_then_prog;
        logic unlocked;
        logic auto_crc;
        logic crc_err;
        ecpc_byte_t live_crc;
        ecpc_byte_t stored_crc;
        ecpc_byte_t prog_count;
        logic [6:0] ptr;
        ecpc_addr_t nv_addr;
        ecpc_addr_t ram_addr;
        ecpc_byte_t rdata;
        logic rvalid;
        ecpc_byte_t ld_data;
        ecpc_addr_t ld_addr;
        logic ld_we;
        logic rd_pending;
    } ecpc_state_s;

    ecpc_state_s s_q, s_d;

    // Memory ports
    logic ram_we, nv_we;
    ecpc_addr_t ram_wa, nv_wa, ram_ra, nv_ra;
    ecpc_byte_t ram_wd, nv_wd, ram_rd, nv_rd;

    ecpc_mem #(.WORDS(`ECPC_ARRAY_WORDS), .AW(5)) u_shadow (
        .sys_clk(sys_clk),
        .wr_en(ram_we),
        .wr_addr(ram_wa),
        .wr_data(ram_wd),
        .rd_addr(ram_ra),
        .rd_data(ram_rd)
    );

    ecpc_mem #(.WORDS(`ECPC_ARRAY_WORDS), .AW(5)) u_nvarray (
        .sys_clk(sys_clk),
        .wr_en(nv_we),
        .wr_addr(nv_wa),
        .wr_data(nv_wd),
        .rd_addr(nv_ra),
        .rd_data(nv_rd)
    );

    function automatic ecpc_byte_t crc_step(ecpc_byte_t crc, ecpc_byte_t data);
        ecpc_byte_t c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `ECPC_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic wr_ctl, wr_key, go_erase, go_prog, busy_now;
    ecpc_addr_t idx5;
    ecpc_byte_t live_byte;

    always_comb begin
        s_d = s_q;
        s_d.ld_we = 1'b0;
        s_d.rvalid = 1'b0;
        ram_we = 1'b0;
        nv_we = 1'b0;
        ram_wa = s_q.ram_addr;
        ram_wd = reg_wdata;
        nv_wa = s_q.idx[4:0];
        nv_wd = 8'hFF;
        idx5 = s_q.idx[4:0];
        ram_ra = s_q.ram_addr;
        nv_ra = s_q.nv_addr;
        live_byte = live_regs[idx5[3:0]*8 +: 8];
        wr_ctl = reg_wr && reg_addr == `ECPC_OFF_NV_CONTROL;
        wr_key = reg_wr && reg_addr == `ECPC_OFF_UNLOCK_KEY;
        busy_now = s_q.st inside {ECPC_ERASE, ECPC_PROG, ECPC_SUM};
        // Requests while busy are dropped outright
        go_erase = wr_ctl && reg_wdata[`ECPC_BIT_ERASE] && s_q.unlocked
            && !busy_now;
        go_prog = wr_ctl && reg_wdata[`ECPC_BIT_PROGRAM] && s_q.unlocked
            && !busy_now;
        // Any transaction relocks; only the key write itself arms the next one
        if (reg_wr || reg_rd) begin
            s_d.unlocked = wr_key && reg_wdata == `ECPC_UNLOCK_VALUE;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `ECPC_OFF_NV_CONTROL: begin
                    s_d.auto_crc = reg_wdata[`ECPC_BIT_AUTO_CRC];
                end
                `ECPC_OFF_ARRAY_PTR: begin
                    s_d.ptr = reg_wdata[6:0];
                    s_d.nv_addr = reg_wdata[4:0];
                    s_d.ram_addr = reg_wdata[4:0];
                end
                `ECPC_OFF_SHADOW_RAM: begin
                    if (!busy_now) begin
                        ram_we = 1'b1;
                        s_d.ram_addr = s_q.ram_addr + 5'h01;
                    end
                end
                default: ;
            endcase
        end

        // Register reads, one cycle late, held off during a load
        if (reg_rd && s_q.st != ECPC_LOAD) begin
            s_d.rvalid = 1'b1;
            unique case (reg_addr)
                `ECPC_OFF_NV_CONTROL: s_d.rdata = {1'b0, 1'b0, s_q.crc_err, s_q.auto_crc,
                    1'b0, busy_now, 2'b00};
                `ECPC_OFF_LIVE_CRC: s_d.rdata = s_q.live_crc;
                `ECPC_OFF_STORED_CRC: s_d.rdata = s_q.stored_crc;
                `ECPC_OFF_PROG_COUNT: s_d.rdata = s_q.prog_count;
                `ECPC_OFF_ARRAY_PTR: s_d.rdata = {1'b0, s_q.ptr};
                `ECPC_OFF_UNLOCK_KEY: s_d.rdata = `ECPC_RST_ZERO;
                `ECPC_OFF_NV_READ: begin
                    // Busy array reads as zero and the address stays put
                    s_d.rdata = busy_now ? `ECPC_RST_ZERO : nv_rd;
                    if (!busy_now) begin
                        s_d.nv_addr = s_q.nv_addr + 5'h01;
                        nv_ra = s_q.nv_addr + 5'h01;
                    end
                end
                `ECPC_OFF_SHADOW_RAM: begin
                    s_d.rdata = ram_rd;
                    s_d.ram_addr = s_q.ram_addr + 5'h01;
                    ram_ra = s_q.ram_addr + 5'h01;
                end
                default: s_d.rdata = `ECPC_RST_ZERO;
            endcase
        end

        // ****************************************
        // Sequencer
        // ****************************************
        unique case (s_q.st)
            ECPC_IDLE: begin
                s_d.idx = 6'h00;
                s_d.timer = 32'h0;
                s_d.live_crc = `ECPC_RST_ZERO;
                nv_ra = (wr_ctl && reg_wdata[`ECPC_BIT_NV_LOAD]) || s_q.rd_pending ? 5'h00
                    : nv_ra;
                // Load queued by reset waits one cycle so byte 0 is read first
                if (s_q.rd_pending) begin
                    s_d.st = ECPC_LOAD;
                    s_d.rd_pending = 1'b0;
                end else if (go_erase) begin
                    s_d.st = ECPC_ERASE;
                    s_d.erase_then_prog = go_prog;
                end else if (go_prog) begin
                    s_d.st = ECPC_PROG;
                end else if (wr_ctl && reg_wdata[`ECPC_BIT_NV_LOAD]) begin
                    s_d.st = ECPC_LOAD;
                end else if (wr_ctl && reg_wdata[`ECPC_BIT_REG_COPY]) begin
                    s_d.st = ECPC_COPY;
                end
            end
            ECPC_LOAD: begin
                // nv_rd holds the byte addressed one cycle earlier
                nv_ra = s_q.idx[4:0] + 5'h01;
                s_d.ld_data = nv_rd;
                s_d.ld_addr = idx5;
                s_d.ld_we = idx5 < 5'(LIVE_REGS);
                s_d.idx = s_q.idx + 6'h01;
                if (idx5 == `ECPC_COUNT_ADDR) begin
                    s_d.prog_count = nv_rd;
                end
                if (idx5 == `ECPC_CRC_ADDR) begin
                    s_d.stored_crc = nv_rd;
                    s_d.crc_err = nv_rd != s_q.live_crc;
                    s_d.st = ECPC_IDLE;
                end else begin
                    s_d.live_crc = crc_step(s_q.live_crc, nv_rd);
                end
            end
            ECPC_COPY: begin
                ram_we = 1'b1;
                ram_wa = idx5;
                ram_wd = live_byte;
                s_d.idx = s_q.idx + 6'h01;
                if (idx5 == 5'(LIVE_REGS - 1)) begin
                    s_d.st = ECPC_IDLE;
                end
            end
            ECPC_ERASE, ECPC_PROG: begin
                // Erase writes the array over the first 32 clocks; program writes it after the long cycle
                s_d.timer = s_q.timer + 32'h1;
                if (s_q.timer == 32'(CYCLE_CLKS - 1)) begin
                    s_d.timer = 32'h0;
                    s_d.idx = 6'h00;
                    if (s_q.st == ECPC_ERASE) begin
                        nv_we = 1'b1;
                        s_d.idx = 6'h01;
                        s_d.st = s_q.erase_then_prog ? ECPC_PROG : ECPC_IDLE;
                        s_d.erase_then_prog = 1'b0;
                        if (!s_q.erase_then_prog && s_q.prog_count != `ECPC_COUNT_MAX) begin
                            s_d.prog_count = s_q.prog_count + 8'h01;
                        end
                    end else begin
                        // Prime the shadow read so the copy starts at byte 0
                        ram_ra = 5'h00;
                        s_d.st = ECPC_SUM;
                    end
                end else if (s_q.st == ECPC_ERASE && s_q.idx < 6'(`ECPC_ARRAY_WORDS)) begin
                    nv_we = 1'b1;
                    s_d.idx = s_q.idx + 6'h01;
                end
            end
            ECPC_SUM: begin
                // Copy shadow into the array, count and checksum at the top
                ram_ra = idx5 + 5'h01;
                nv_we = 1'b1;
                s_d.idx = s_q.idx + 6'h01;
                if (idx5 == `ECPC_COUNT_ADDR) begin
                    nv_wd = s_q.prog_count == `ECPC_COUNT_MAX ? s_q.prog_count
                        : s_q.prog_count + 8'h01;
                    s_d.prog_count = nv_wd;
                    s_d.live_crc = crc_step(s_q.live_crc, nv_wd);
                end else if (idx5 == `ECPC_CRC_ADDR) begin
                    nv_wd = s_q.auto_crc ? s_q.live_crc : ram_rd;
                    s_d.stored_crc = nv_wd;
                    s_d.st = ECPC_IDLE;
                end else begin
                    nv_wd = ram_rd;
                    s_d.live_crc = crc_step(s_q.live_crc, ram_rd);
                end
            end
            default: s_d.st = ECPC_IDLE;
        endcase
        if (s_q.st == ECPC_SUM && s_q.idx == 6'h00) begin
            ram_ra = 5'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ECPC_IDLE;
            s_q.rd_pending <= 1'b1;
            s_q.auto_crc <= `ECPC_RST_AUTO_CRC;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        reg_rdata = s_q.rdata;
        reg_rvalid = s_q.rvalid;
        load_data = s_q.ld_data;
        load_addr = s_q.ld_addr;
        load_we = s_q.ld_we;
        nv_busy = s_q.st inside {ECPC_ERASE, ECPC_PROG, ECPC_SUM};
        load_active = s_q.st == ECPC_LOAD;
    end
endmodule // ecpc_top

// ---- ecpc_chk.sv ----
// Purpose: port checks for ecpc_top
// Assumes: one clock domain, rstn active low
// Notes: busy upper bound is loose since erase then program runs two cycles
`include "ecpc_regs.svh"
module ecpc_chk #(
    parameter int CYCLE_CLKS = 50
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Status
    input wire logic load_we,
    input wire logic nv_busy,
    input wire logic load_active
);
    logic [31:0] busy_q;
    logic [7:0] load_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 32'h0;
            load_q <= 8'h0;
        end else begin
            busy_q <= nv_busy ? busy_q + 32'h1 : 32'h0;
            load_q <= load_active ? load_q + 8'h1 : 8'h0;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (reg_rd && !load_active |=> reg_rvalid)
        else $error("read not answered");
    a_load_no_read: assert property (reg_rd && load_active |=> !reg_rvalid)
        else $error("read answered during load");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read data without read");
    a_busy_start: assert property ($rose(nv_busy) |-> $past(reg_wr)
        && $past(reg_addr) == `ECPC_OFF_NV_CONTROL && $past(reg_wdata[1:0]) != 2'h0)
        else $error("busy without start request");
    a_busy_long: assert property ($fell(nv_busy) |-> busy_q >= CYCLE_CLKS)
        else $error("busy too short");
    a_busy_bound: assert property (nv_busy |-> busy_q < 4 * CYCLE_CLKS + 256)
        else $error("busy too long");
    a_load_length: assert property ($fell(load_active) |-> load_q == 8'h20)
        else $error("load length wrong");
    a_reset_load: assert property ($rose(rstn) |-> ##[1:6] load_active)
        else $error("no load after reset");
    a_load_we_in: assert property (load_we |-> load_active || $past(load_active))
        else $error("load write outside load");
    a_busy_read_zero: assert property (reg_rd && nv_busy
        && reg_addr == `ECPC_OFF_NV_READ |=> reg_rdata == 8'h00)
        else $error("array read while busy");
    a_ctl_readback: assert property (reg_rd && !load_active
        && reg_addr == `ECPC_OFF_NV_CONTROL
        |=> (reg_rdata & 8'h4B) == 8'h00 && reg_rdata[2] == $past(nv_busy))
        else $error("control readback wrong");
    a_key_read_zero: assert property (reg_rd && !load_active
        && reg_addr == `ECPC_OFF_UNLOCK_KEY |=> reg_rdata == 8'h00)
        else $error("unlock key readable");
    c_cycle: cover property ($rose(nv_busy));
    c_load: cover property ($rose(load_active));
    c_busy_read: cover property (reg_rd && nv_busy);
endmodule // ecpc_chk
bind ecpc_top ecpc_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .load_we(load_we),
    .nv_busy(nv_busy), .load_active(load_active));

// ---- ecpc_live_model.sv ----
// Purpose: live configuration registers fed by the load writes
// Assumes: byte i of live_regs sits at bits [8i+7:8i]
// Notes: addresses above the live range are dropped, as the real file has no such bytes
module ecpc_live_model #(
    parameter int LIVE_REGS = 16
) (
    // Clock
    input wire logic sys_clk,
    // Load writes
    input wire logic load_we,
    input wire logic [4:0] load_addr,
    input wire logic [7:0] load_data,
    // Live bytes
    output logic [LIVE_REGS*8-1:0] live_regs
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [LIVE_REGS];
    always @(posedge sys_clk) begin
        if (load_we && int'(load_addr) < LIVE_REGS) begin
            mem[load_addr] <= load_data;
        end
    end
    always_comb begin
        for (int i = 0; i < LIVE_REGS; i++) begin
            live_regs[i*8 +: 8] = mem[i];
        end
    end
endmodule // ecpc_live_model

// ---- tb.sv ----
// Purpose: directed tests of ecpc_top through its register port
// Assumes: cycle length shortened to 50 clocks
// Notes: array starts cleared; array checks follow a full shadow fill
`include "ecpc_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, load_data, d;
    logic reg_rvalid, load_we, nv_busy, load_active, ok;
    logic [4:0] load_addr;
    logic [127:0] live_regs;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    ecpc_top #(.CYCLE_CLKS(50), .LIVE_REGS(16)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .live_regs(live_regs),
        .load_data(load_data), .load_addr(load_addr), .load_we(load_we),
        .nv_busy(nv_busy), .load_active(load_active));
    ecpc_live_model #(.LIVE_REGS(16)) live (.sys_clk(sys_clk), .load_we(load_we),
        .load_addr(load_addr), .load_data(load_data), .live_regs(live_regs));
    function automatic logic [7:0] pat(input int i);
        return 8'hA5 ^ 8'(i * 7);
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] cnt);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 31; i++) begin
            c = c ^ (i < 30 ? pat(i) : cnt);
            for (int b = 0; b < 8; b++) begin
                c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
            end
        end
        return c;
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        if (ok !== 1'b1) d = 8'hXX;
        chk(d & m, e);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge sys_clk);
        while ((nv_busy | load_active) !== 1'b0 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        #1 chk({7'h0, nv_busy | load_active}, 8'h00);
    endtask
    task automatic prog(input logic [7:0] cmd);
        wr(`ECPC_OFF_UNLOCK_KEY, `ECPC_UNLOCK_VALUE);
        wr(`ECPC_OFF_NV_CONTROL, cmd);
        @(posedge sys_clk);
        #1 chk({7'h0, nv_busy}, 8'h01);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1'b1;
        wait_idle();
        rc(`ECPC_OFF_NV_CONTROL, 8'h5F, 8'h10);
        rc(`ECPC_OFF_ARRAY_PTR, 8'hFF, 8'h00);
        rc(`ECPC_OFF_UNLOCK_KEY, 8'hFF, 8'h00);
        $display("test reset values done");
        wr(`ECPC_OFF_ARRAY_PTR, 8'h60);
        for (int i = 0; i < 32; i++) wr(`ECPC_OFF_SHADOW_RAM, pat(i));
        rc(`ECPC_OFF_ARRAY_PTR, 8'hFF, 8'h60);
        wr(`ECPC_OFF_ARRAY_PTR, 8'h42);
        for (int i = 2; i < 5; i++) rc(`ECPC_OFF_SHADOW_RAM, 8'hFF, pat(i));
        $display("test shadow port done");
        wr(`ECPC_OFF_NV_CONTROL, 8'h11);
        wr(`ECPC_OFF_UNLOCK_KEY, 8'h3C);
        wr(`ECPC_OFF_NV_CONTROL, 8'h11);
        wr(`ECPC_OFF_UNLOCK_KEY, `ECPC_UNLOCK_VALUE);
        rd(`ECPC_OFF_UNLOCK_KEY);
        wr(`ECPC_OFF_NV_CONTROL, 8'h11);
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h0, nv_busy}, 8'h00);
        $display("test locked start done");
        prog(8'h11);
        rc(`ECPC_OFF_NV_CONTROL, 8'h07, 8'h04);
        rc(`ECPC_OFF_NV_READ, 8'hFF, 8'h00);
        wait_idle();
        wr(`ECPC_OFF_ARRAY_PTR, 8'h00);
        for (int i = 0; i < 30; i++) rc(`ECPC_OFF_NV_READ, 8'hFF, pat(i));
        rd(`ECPC_OFF_NV_READ);
        rc(`ECPC_OFF_NV_READ, 8'hFF, crc8(8'h01));
        $display("test program done");
        wr(`ECPC_OFF_NV_CONTROL, 8'h18);
        rd(`ECPC_OFF_ARRAY_PTR);
        chk({7'h0, ok}, 8'h00);
        wait_idle();
        for (int i = 0; i < 16; i++) chk(live_regs[i*8 +: 8], pat(i));
        rc(`ECPC_OFF_STORED_CRC, 8'hFF, crc8(8'h01));
        rc(`ECPC_OFF_NV_CONTROL, 8'h28, 8'h00);
        wr(`ECPC_OFF_ARRAY_PTR, 8'h00);
        wr(`ECPC_OFF_SHADOW_RAM, 8'hEE);
        wr(`ECPC_OFF_NV_CONTROL, 8'h50);
        repeat (60) @(posedge sys_clk);
        rc(`ECPC_OFF_NV_CONTROL, 8'h40, 8'h00);
        wr(`ECPC_OFF_ARRAY_PTR, 8'h00);
        rc(`ECPC_OFF_SHADOW_RAM, 8'hFF, pat(0));
        rd(`ECPC_OFF_LIVE_CRC);
        wr(`ECPC_OFF_LIVE_CRC, ~d);
        rc(`ECPC_OFF_LIVE_CRC, 8'hFF, d);
        $display("test load and copy done");
        prog(8'h12);
        wait_idle();
        wr(`ECPC_OFF_ARRAY_PTR, 8'h00);
        rc(`ECPC_OFF_NV_READ, 8'hFF, 8'hFF);
        prog(8'h13);
        wait_idle();
        wr(`ECPC_OFF_ARRAY_PTR, 8'h00);
        rc(`ECPC_OFF_NV_READ, 8'hFF, pat(0));
        $display("test erase done");
        wr(`ECPC_OFF_ARRAY_PTR, 8'h00);
        wr(`ECPC_OFF_SHADOW_RAM, 8'h00);
        prog(8'h01);
        wait_idle();
        #1 rstn = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1'b1;
        wait_idle();
        rc(`ECPC_OFF_NV_CONTROL, 8'h30, 8'h30);
        $display("test checksum error done");
        finish_test();
    end
endmodule // tb
